//--- src/haa_pkg.sv
// Package of constants and carrier types for the board address arbitration block.
package haa_pkg;

    // ****************************************************************
    // Command codes carried on the management bus.
    // ****************************************************************
    localparam logic [7:0] CMD_ARB_REQUEST = 8'h08;
    localparam logic [7:0] CMD_REARBITRATE = 8'h10;
    localparam logic [7:0] CMD_ASSIGN_CHAIN = 8'h14;
    localparam logic [7:0] CMD_GRANT_LOW = 8'h1c;
    localparam logic [7:0] CMD_GRANT_HIGH = 8'h0c;
    localparam logic [7:0] CMD_ASSIGN_ROM = 8'h18;
    localparam logic [7:0] CMD_CONFIG_CHANGE = 8'h00;

    // ****************************************************************
    // Widths and positions.
    // ****************************************************************
    localparam int BOARD_ID_W = 5;
    localparam int ROM_ID_W = 48;
    localparam int ROM_WORD_W = 16;
    localparam logic [5:0] ROM_TOP_BIT = 6'h2f;
    localparam logic [5:0] ROM_BITS = 6'h30;
    localparam logic [BOARD_ID_W-1:0] BOARD_ID_BCAST = 5'h1f;
    localparam logic [1:0] POS_FIRST = 2'h0;
    localparam logic [BOARD_ID_W-1:0] BOARD_ID_NONE = 5'h00;

    // ****************************************************************
    // Timing: request interval 2 to 3 ms, ROM clock divider.
    // ****************************************************************
    localparam int CLK_MHZ = 100;
    localparam int REQ_INTERVAL_US = 2500;
    localparam int REQ_INTERVAL_CYC = REQ_INTERVAL_US * CLK_MHZ;
    localparam int ROM_DIV_CYC = 8;
    localparam logic [3:0] ROM_SETUP_CYC = 4'h4;

    // Incoming command from the management bus receiver.
    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [BOARD_ID_W-1:0] board_id;
        logic [2:0] chip_addr;
        logic [BOARD_ID_W-1:0] new_id;
        logic [ROM_ID_W-1:0] rom_id;
    } haa_cmd_s;

    // Message request toward the management bus transmitter.
    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [ROM_ID_W-1:0] payload;
    } haa_msg_s;

endpackage : haa_pkg

//--- src/haa_arbiter.sv
// Board address arbitration: chain grant, serial ROM reader and requests.
`timescale 1ns/1ns
`default_nettype none

module haa_arbiter (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic arb_method_select,
    input wire logic chain_grant_in,
    input wire logic [1:0] chip_position_pins,
    input wire logic request_in_a,
    input wire haa_pkg::haa_cmd_s cmd_in,
    input wire logic ordinary_pending,
    input wire logic msg_ready,
    input wire logic bus_collision,
    input wire logic rom_data_in,
    input wire logic rom_clk_in,
    output logic chain_grant_out,
    output logic [haa_pkg::BOARD_ID_W-1:0] board_identifier,
    output logic id_assigned,
    output logic [2:0] chip_address,
    output logic first_in_chain,
    output logic [haa_pkg::ROM_ID_W-1:0] rom_id,
    output logic rom_loaded,
    output haa_pkg::haa_msg_s msg_out,
    output logic ordinary_hold,
    output logic rom_clk_out,
    output logic rom_clk_oe,
    output logic rom_cs_out,
    output logic rom_cs_oe
);
    import haa_pkg::*;

    // ****************************************************************
    // Derived timing constants.
    // ****************************************************************
    localparam logic [17:0] REQ_CYC = 18'(REQ_INTERVAL_CYC);
    localparam logic [3:0] DIV_CYC = 4'(ROM_DIV_CYC);

    // ****************************************************************
    // Serial ROM reader state.
    // ****************************************************************
    typedef enum {ROM_IDLE, ROM_SETUP, ROM_SHIFT, ROM_DONE} haa_rom_e;

    haa_rom_e rom_st_r, rom_st_nxt;      // Reader sequence state.
    logic [3:0] div_r, div_nxt;          // ROM clock divider.
    logic [5:0] bit_cnt_r, bit_cnt_nxt;  // Bits captured so far.
    logic [ROM_ID_W-1:0] rom_id_r, rom_id_nxt;
    logic rclk_r, rclk_nxt;              // Driven ROM clock.
    logic rcs_r, rcs_nxt;                // Driven ROM select.
    logic rclk_prev_r, rclk_prev_nxt;    // Last sampled ROM clock.
    logic is_first;                      // Position 00 device.
    logic rise;                          // Sampled rising ROM clock.

    // The master owns the lines; listeners only sample them.
    assign is_first = (chip_position_pins == POS_FIRST);
    assign rise = rom_clk_in && !rclk_prev_r;

    // Next state of the reader; it only ever runs once after reset.
    always_comb begin
        rom_st_nxt = rom_st_r;
        div_nxt = div_r;
        bit_cnt_nxt = bit_cnt_r;
        rom_id_nxt = rom_id_r;
        rclk_nxt = rclk_r;
        rcs_nxt = rcs_r;
        rclk_prev_nxt = rom_clk_in;
        case (rom_st_r)
            ROM_IDLE: begin
                // Listeners wait for edges; the master starts its cycle.
                rom_st_nxt = ROM_SETUP;
                rcs_nxt = is_first;
                div_nxt = '0;
            end
            ROM_SETUP: begin
                div_nxt = div_r + 4'h1;
                if (div_r == ROM_SETUP_CYC) begin
                    rom_st_nxt = ROM_SHIFT;
                    div_nxt = '0;
                end
            end
            ROM_SHIFT: begin
                // Master toggles the ROM clock from a divider.
                if (is_first) begin
                    div_nxt = div_r + 4'h1;
                    if (div_r == DIV_CYC - 4'h1) begin
                        div_nxt = '0;
                        rclk_nxt = !rclk_r;
                    end
                end
                // Every device captures on the sampled clock rise.
                if (rise) begin
                    // First bit lands at bit 47, MSB of each word first.
                    rom_id_nxt = {rom_id_r[ROM_ID_W-2:0], rom_data_in};
                    bit_cnt_nxt = bit_cnt_r + 6'h1;
                    if (bit_cnt_r == ROM_BITS - 6'h1) begin
                        rom_st_nxt = ROM_DONE;
                        rcs_nxt = 1'b0;
                        rclk_nxt = 1'b0;
                    end
                end
            end
            ROM_DONE: begin
                rom_st_nxt = ROM_DONE;
            end
            default: begin
                rom_st_nxt = ROM_IDLE;
            end
        endcase
    end

    // Registers of the reader.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rom_st_r <= ROM_IDLE;
            div_r <= '0;
            bit_cnt_r <= '0;
            rom_id_r <= '0;
            rclk_r <= 1'b0;
            rcs_r <= 1'b0;
            rclk_prev_r <= 1'b0;
        end else begin
            rom_st_r <= rom_st_nxt;
            div_r <= div_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            rom_id_r <= rom_id_nxt;
            rclk_r <= rclk_nxt;
            rcs_r <= rcs_nxt;
            rclk_prev_r <= rclk_prev_nxt;
        end
    end

    // ****************************************************************
    // Address assignment, grant chain and message requests.
    // ****************************************************************
    logic grant_r, grant_nxt;
    logic [BOARD_ID_W-1:0] bid_r, bid_nxt;
    logic asg_r, asg_nxt;
    logic [17:0] tmr_r, tmr_nxt;         // Request interval counter.
    logic req_pend_r, req_pend_nxt;      // Request awaiting the bus.
    logic chg_pend_r, chg_pend_nxt;      // Change message pending.
    logic recfg_prev_r, recfg_prev_nxt;  // Last reconfiguration level.
    haa_msg_s msg_r, msg_nxt;
    logic hold_r, hold_nxt;
    logic for_me;                        // Command addressed to us.
    logic chain_mode;

    assign chain_mode = arb_method_select;
    assign for_me = cmd_in.valid &&
        ((cmd_in.board_id == bid_r &&
          cmd_in.chip_addr == {1'b0, chip_position_pins}) ||
         cmd_in.board_id == BOARD_ID_BCAST);

    // Next values of the assignment logic.
    always_comb begin
        grant_nxt = grant_r;
        bid_nxt = bid_r;
        asg_nxt = asg_r;
        tmr_nxt = tmr_r;
        req_pend_nxt = req_pend_r;
        chg_pend_nxt = chg_pend_r;
        recfg_prev_nxt = request_in_a;
        msg_nxt = msg_r;
        // Rising edge, or high at reset via the low reset value.
        if (request_in_a && !recfg_prev_r) begin
            chg_pend_nxt = 1'b1;
        end
        // Chain assignment only for the device with grant 0 / 1.
        if (chain_mode && cmd_in.valid && cmd_in.cmd == CMD_ASSIGN_CHAIN
            && !chain_grant_in && grant_r) begin
            bid_nxt = cmd_in.new_id;
            asg_nxt = 1'b1;
        end
        // Grant output control, direct or broadcast.
        if (for_me && cmd_in.cmd == CMD_GRANT_LOW) begin
            grant_nxt = 1'b0;
        end
        if (for_me && cmd_in.cmd == CMD_GRANT_HIGH) begin
            grant_nxt = 1'b1;
        end
        // ROM mode: adopt only on a matching 48-bit identifier.
        if (!chain_mode && cmd_in.valid && cmd_in.cmd == CMD_ASSIGN_ROM
            && rom_st_r == ROM_DONE && cmd_in.rom_id == rom_id_r) begin
            bid_nxt = cmd_in.new_id;
            asg_nxt = 1'b1;
        end
        // Re-arbitrate drops the assignment and re-enters.
        if (cmd_in.valid && cmd_in.cmd == CMD_REARBITRATE) begin
            bid_nxt = BOARD_ID_NONE;
            asg_nxt = 1'b0;
            grant_nxt = 1'b1;
            tmr_nxt = '0;
        end
        // Periodic request while unassigned, from position 00 only.
        if (!chain_mode && is_first && !asg_r && rom_st_r == ROM_DONE) begin
            tmr_nxt = tmr_r + 18'h1;
            if (tmr_r == REQ_CYC - 18'h1) begin
                tmr_nxt = '0;
                req_pend_nxt = 1'b1;
            end
        end else begin
            tmr_nxt = '0;
        end
        if (asg_r) begin
            req_pend_nxt = 1'b0;
        end
        // Present one message; arbitration ahead of change message.
        if (msg_r.valid) begin
            if (msg_ready) begin
                msg_nxt.valid = 1'b0;
            end else if (bus_collision) begin
                // Lost the bus: withdraw; a request retries next interval, a change message is dropped.
                msg_nxt.valid = 1'b0;
            end
        end else if (req_pend_r && !asg_r) begin
            msg_nxt = '{valid: 1'b1, cmd: CMD_ARB_REQUEST,
                        payload: rom_id_r};
            req_pend_nxt = 1'b0;
        end else if (chg_pend_r) begin
            msg_nxt = '{valid: 1'b1, cmd: CMD_CONFIG_CHANGE,
                        payload: '0};
            chg_pend_nxt = request_in_a && !recfg_prev_r; // A fresh rise wins.
        end
        // Ordinary traffic waits while arbitration traffic exists.
        hold_nxt = req_pend_nxt || (msg_nxt.valid &&
            msg_nxt.cmd == CMD_ARB_REQUEST) || ordinary_pending &&
            req_pend_r;
    end

    // Registers of the assignment logic.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            grant_r <= 1'b1;
            bid_r <= BOARD_ID_NONE;
            asg_r <= 1'b0;
            tmr_r <= '0;
            req_pend_r <= 1'b0;
            chg_pend_r <= 1'b0;
            recfg_prev_r <= 1'b0;
            msg_r <= '0;
            hold_r <= 1'b0;
        end else begin
            grant_r <= grant_nxt;
            bid_r <= bid_nxt;
            asg_r <= asg_nxt;
            tmr_r <= tmr_nxt;
            req_pend_r <= req_pend_nxt;
            chg_pend_r <= chg_pend_nxt;
            recfg_prev_r <= recfg_prev_nxt;
            msg_r <= msg_nxt;
            hold_r <= hold_nxt;
        end
    end

    // ****************************************************************
    // Output registers.
    // ****************************************************************
    logic [2:0] caddr_r;
    logic fic_r;

    // Position-derived status, registered so outputs leave flops.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            caddr_r <= '0;
            fic_r <= 1'b0;
        end else begin
            caddr_r <= {1'b0, chip_position_pins};
            fic_r <= chain_mode && is_first;
        end
    end

    assign chain_grant_out = grant_r;
    assign board_identifier = bid_r;
    assign id_assigned = asg_r;
    assign chip_address = caddr_r;
    assign first_in_chain = fic_r;
    assign rom_id = rom_id_r;
    assign rom_loaded = (rom_st_r == ROM_DONE);
    assign msg_out = msg_r;
    assign ordinary_hold = hold_r;
    assign rom_clk_out = rclk_r;
    assign rom_cs_out = rcs_r;
    assign rom_clk_oe = is_first && rom_st_r != ROM_DONE;
    assign rom_cs_oe = is_first && rom_st_r != ROM_DONE;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb_arb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_grant_low_cmd: assert property (
        for_me && cmd_in.cmd == CMD_GRANT_LOW |=> !chain_grant_out)
        else $error("grant not lowered");
    a_chain_accept: assert property (
        $rose(id_assigned) && arb_method_select |-> !$past(chain_grant_in)
        && $past(chain_grant_out)) else $error("bad chain assign");
    a_rom_load_once: assert property (rom_loaded |=> rom_loaded)
        else $error("reload");
    a_rom_drive_pos: assert property (
        rom_clk_oe |-> chip_position_pins == POS_FIRST)
        else $error("non-first drives rom");
    a_chip_addr_msb: assert property (!chip_address[2])
        else $error("chip msb set");
    a_no_req_assigned: assert property (
        id_assigned && !msg_out.valid |=> !(msg_out.valid &&
        msg_out.cmd == CMD_ARB_REQUEST)) else $error("req after asg");
    a_rearb_clears: assert property (
        cmd_in.valid && cmd_in.cmd == CMD_REARBITRATE |=>
        !id_assigned && chain_grant_out) else $error("rearb");
    a_recfg_msg: assert property (
        $rose(request_in_a) && !msg_out.valid && !req_pend_r &&
        !req_pend_nxt |-> ##[1:3] msg_out.valid) else $error("no change msg");

endmodule : haa_arbiter

`default_nettype wire

//--- verif/haa_rom_model.sv
// Behavioural serial identifier ROM that sits on the board beside the block.
`timescale 1ns/1ns
`default_nettype none

module haa_rom_model #(
    parameter logic [47:0] ROM_VALUE = 48'h0 // Board serial, arbitrary.
) (
    input wire logic rom_clk,
    input wire logic selected,
    output logic rom_data
);
    // ****************************************************************
    // Shift state.
    // ****************************************************************
    // Bit index counts straight down through three auto-incremented words.
    logic [5:0] idx = 6'h2f;
    // Set once a rising edge has been seen, so an idle-high clock's first
    // falling edge cannot skip the top bit.
    logic rose = 1'b0;

    // Remember whether a rising edge happened while selected; dropping
    // the select forgets it, so every new read starts clean.
    always @(posedge rom_clk or negedge selected) begin
        if (!selected) begin
            rose <= 1'b0;
        end else begin
            rose <= 1'b1;
        end
    end

    // The ROM moves to the next bit on the falling edge, MSB of each word
    // first, and rolls into the next word without a new address. A
    // deselect, as on every power cycle of the reader, restarts at the top.
    always @(negedge rom_clk or negedge selected) begin
        if (!selected) begin
            idx <= 6'h2f;
        end else if (rose && idx != 6'h0) begin
            idx <= idx - 6'h1;
        end
    end

    // When deselected the line shows the inverse, never a stale bit.
    assign rom_data = selected ? ROM_VALUE[idx] : ~ROM_VALUE[idx];

endmodule : haa_rom_model

`default_nettype wire

//--- verif/tb_haa_arbiter.sv
// Self-checking testbench for the board address arbitration block.
`timescale 1ns/1ns
`default_nettype none

module tb_haa_arbiter;
    import haa_pkg::*;

    // ****************************************************************
    // Signals.
    // ****************************************************************
    localparam logic [47:0] ROM_VAL = 48'ha5c3_1e7f_9b24; // Arbitrary.
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic method = 1'b1, grant_in = 1'b1, req_a = 1'b0, ord_pend = 1'b0;
    logic ready = 1'b0, coll = 1'b0;
    logic [1:0] pins = 2'h0;
    haa_cmd_s cmd = '0;
    logic grant_out, assigned, loaded, hold, first, rdata;
    logic rclk_out, rclk_oe, rcs_out, rcs_oe;
    logic [4:0] bid;
    logic [2:0] caddr;
    logic [47:0] rid;
    haa_msg_s msg;
    // The ROM clock has a pull-down, so a released line reads low.
    wire logic rclk_wire = rclk_oe ? rclk_out : 1'b0;
    // The ROM select has a pull-down as well; a released select deselects.
    wire logic rcs_wire = rcs_oe ? rcs_out : 1'b0;
    int failures = 0;
    int num_checks = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    haa_arbiter i_haa_arbiter (.clk(clk), .reset_n(reset_n),
        .arb_method_select(method), .chain_grant_in(grant_in),
        .chip_position_pins(pins), .request_in_a(req_a), .cmd_in(cmd),
        .ordinary_pending(ord_pend), .msg_ready(ready),
        .bus_collision(coll), .rom_data_in(rdata), .rom_clk_in(rclk_wire),
        .chain_grant_out(grant_out), .board_identifier(bid),
        .id_assigned(assigned), .chip_address(caddr),
        .first_in_chain(first), .rom_id(rid), .rom_loaded(loaded),
        .msg_out(msg), .ordinary_hold(hold), .rom_clk_out(rclk_out),
        .rom_clk_oe(rclk_oe), .rom_cs_out(rcs_out), .rom_cs_oe(rcs_oe));

    haa_rom_model #(.ROM_VALUE(ROM_VAL)) i_haa_rom_model (
        .rom_clk(rclk_wire), .selected(rcs_wire), .rom_data(rdata));

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    // Compare one value; narrow values are zero-extended.
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Print the verdict and stop.
    task automatic finish_test();
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Power-cycle the block with new strap pins for 16 cycles.
    task automatic do_reset(input logic m, input logic [1:0] p, input logic r);
        reset_n = 1'b0;
        method = m;
        pins = p;
        req_a = r;
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        // Strap-derived outputs are registered and load after release.
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset

    // One-cycle command pulse, then one cycle for the outputs to land.
    task automatic send(input logic [7:0] c, input logic [4:0] b,
                        input logic [2:0] a, input logic [4:0] n,
                        input logic [47:0] r);
        cmd = '{valid: 1'b1, cmd: c, board_id: b, chip_addr: a,
                new_id: n, rom_id: r};
        @(posedge clk);
        #1 cmd.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : send

    // Wait a bounded time for a zero-payload message and check it.
    task automatic wait_msg(input logic [7:0] c);
        for (int i = 0; i < 4; i++) begin
            if (msg.valid === 1'b1) break;
            @(posedge clk);
            #1;
        end
        chk(msg.valid, 1'b1);
        chk(msg.cmd, c);
        chk(msg.payload, 48'h0);
    endtask : wait_msg

    // ****************************************************************
    // Tests.
    // ****************************************************************
    // Chain method first, then message handling, then the ROM method.
    initial begin
        do_reset(1'b1, 2'h0, 1'b0);
        chk(grant_out, 1'b1);
        chk(assigned, 1'b0);
        chk(bid, BOARD_ID_NONE);
        chk(caddr, 3'h0);
        chk(first, 1'b1);
        // Grant input still high, so the assignment must be ignored.
        send(CMD_ASSIGN_CHAIN, BOARD_ID_BCAST, 3'h3, 5'h03, 48'h0);
        chk(assigned, 1'b0);
        // The manager lowers the first grant input of the chain.
        grant_in = 1'b0;
        send(CMD_ASSIGN_CHAIN, BOARD_ID_BCAST, 3'h3, 5'h03, 48'h0);
        chk(bid, 5'h03);
        chk(assigned, 1'b1);
        send(CMD_GRANT_LOW, 5'h03, 3'h0, 5'h0, 48'h0);
        chk(grant_out, 1'b0);
        // Grant output now low, so a second assignment is refused.
        send(CMD_ASSIGN_CHAIN, BOARD_ID_BCAST, 3'h3, 5'h07, 48'h0);
        chk(bid, 5'h03);
        send(CMD_GRANT_HIGH, BOARD_ID_BCAST, 3'h3, 5'h0, 48'h0);
        chk(grant_out, 1'b1);
        send(CMD_GRANT_LOW, BOARD_ID_BCAST, 3'h3, 5'h0, 48'h0);
        chk(grant_out, 1'b0);
        send(CMD_REARBITRATE, BOARD_ID_BCAST, 3'h3, 5'h0, 48'h0);
        chk(assigned, 1'b0);
        // Reconfiguration rise, accepted by the transmitter.
        req_a = 1'b1;
        wait_msg(CMD_CONFIG_CHANGE);
        ready = 1'b1;
        @(posedge clk);
        #1 ready = 1'b0;
        chk(msg.valid, 1'b0);
        // Second rise loses bus arbitration and is withdrawn.
        req_a = 1'b0;
        @(posedge clk);
        #1 req_a = 1'b1;
        wait_msg(CMD_CONFIG_CHANGE);
        coll = 1'b1;
        @(posedge clk);
        #1 coll = 1'b0;
        chk(msg.valid, 1'b0);
        // Input already high at power-up also reports a change.
        do_reset(1'b1, 2'h1, 1'b1);
        wait_msg(CMD_CONFIG_CHANGE);
        chk(caddr, 3'h1);
        chk(first, 1'b0);
        // A listening device never drives the ROM lines.
        do_reset(1'b0, 2'h1, 1'b0);
        repeat (50) @(posedge clk);
        #1 chk(rclk_oe | rcs_oe, 1'b0);
        // Position zero reads the ROM, then releases it.
        do_reset(1'b0, 2'h0, 1'b0);
        chk(rcs_oe, 1'b1);
        for (int i = 0; i < 3000 && loaded !== 1'b1; i++) @(posedge clk);
        #1 chk(loaded, 1'b1);
        chk(rid, ROM_VAL);
        chk(rclk_oe | rcs_oe, 1'b0);
        send(CMD_ASSIGN_ROM, BOARD_ID_BCAST, 3'h3, 5'h09,
             ROM_VAL ^ 48'h1);
        chk(assigned, 1'b0);
        send(CMD_ASSIGN_ROM, BOARD_ID_BCAST, 3'h3, 5'h09, ROM_VAL);
        chk(bid, 5'h09);
        // Ordinary traffic waits only for arbitration traffic, none now.
        ord_pend = 1'b1;
        repeat (100) @(posedge clk);
        #1 chk(rid, ROM_VAL);
        chk(msg.valid, 1'b0);
        chk(hold, 1'b0);
        finish_test();
    end

    // Watchdog: the whole sequence needs well under 20000 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end

endmodule : tb_haa_arbiter

`default_nettype wire
